// file: tptz_consts.vh
// tptz_consts.vh: widths, fixed-point layout and reset values of the compensator
// assumes: included by bare name from the design files of the compensator
`ifndef TPTZ_CONSTS_VH
`define TPTZ_CONSTS_VH
`define TPTZ_SAMPLE_W 12
`define TPTZ_COEF_W 18
`define TPTZ_COEF_FRAC 12
`define TPTZ_ERR_W 13
`define TPTZ_ACC_W 48
`define TPTZ_CODE_MAX 12'hfff
`define TPTZ_OUT_RESET 12'h000
`define TPTZ_FIFO_DEPTH 16
`define TPTZ_FIFO_AW 4
`endif

// file: tptz_fifo.v
// tptz_fifo.v: sample FIFO with parameterised width and depth, registered read data
// assumes: one clock, asynchronous active-high reset, depth a power of two
`timescale 1ns/1ps
`include "tptz_consts.vh"
module tptz_fifo #(
   parameter WIDTH = 12,
   parameter DEPTH = `TPTZ_FIFO_DEPTH,
   parameter AW = `TPTZ_FIFO_AW
) (
   input wire mclk,
   input wire rst,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output reg [WIDTH-1:0] out_data,
   output reg out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_reg;
   reg [AW:0] rd_reg;
   wire full;
   wire empty;
   wire push;
   wire pop;

   // pointers carry one extra wrap bit so full and empty are exact
   assign full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
   assign empty = (wr_reg == rd_reg);
   assign in_ready = ~full;
   assign push = in_valid & ~full;
   assign pop = ~empty & (~out_valid | out_ready);

   // storage has no reset, only pointers and the output register do
   always @(posedge mclk) begin
      if (push) begin
         mem[wr_reg[AW-1:0]] <= in_data;
      end
   end

   // read data leaves through an output register
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_reg <= {(AW+1){1'b0}};
         rd_reg <= {(AW+1){1'b0}};
         out_data <= {WIDTH{1'b0}};
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_reg <= wr_reg + {{AW{1'b0}}, 1'b1};
         end
         if (pop) begin
            out_data <= mem[rd_reg[AW-1:0]];
            rd_reg <= rd_reg + {{AW{1'b0}}, 1'b1};
            out_valid <= 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule

// file: tptz_compensator.v
// tptz_compensator.v: two_pole_two_zero_filter voltage-loop compensator with period_hold
// assumes: one sample per switching period arrives with in_valid; period_start marks
// the boundary of each switching period; coefficients are steady while a sample computes
//
// Behaviour
// - output = a1*y1 + a2*y2 + b0*x0 + b1*x1 + b2*x2
// - five coefficients, two feedback and three forward, supplied by input ports
// - the equation runs once for each fresh voltage sample, never otherwise
// - a result computed now is applied from the next switching period onward
// - the demand code holds unchanged for the whole next period
// - demand output is 12-bit, code 4095 is full scale 3.3 V
// - filter result is multiplied by a programmable gain factor
// - filter input is the set point minus the sample, same scaling
`timescale 1ns/1ps
`include "tptz_consts.vh"
module tptz_compensator #(
   parameter SW = `TPTZ_SAMPLE_W,
   parameter CW = `TPTZ_COEF_W,
   parameter CF = `TPTZ_COEF_FRAC
) (
   input wire mclk,
   input wire rst,
   input wire [SW-1:0] sample_data,
   input wire sample_valid,
   output reg sample_ready,
   input wire period_start,
   input wire [SW-1:0] set_point,
   input wire signed [CW-1:0] coef_a1,
   input wire signed [CW-1:0] coef_a2,
   input wire signed [CW-1:0] coef_b0,
   input wire signed [CW-1:0] coef_b1,
   input wire signed [CW-1:0] coef_b2,
   input wire signed [CW-1:0] gain_k,
   output reg [SW-1:0] demand_code,
   output reg demand_update,
   output reg busy
);
   localparam AW = `TPTZ_ACC_W;
   localparam EW = `TPTZ_ERR_W;
   localparam S_IDLE = 3'd0;
   localparam S_MAC = 3'd1;
   localparam S_SCALE = 3'd2;
   localparam S_SAT = 3'd3;
   localparam S_WAIT = 3'd4;

   wire [SW-1:0] fifo_data;
   wire fifo_valid;
   wire fifo_in_ready;
   reg take;
   reg [2:0] state_reg;
   reg [2:0] step_reg;
   reg signed [EW-1:0] x0_reg;
   reg signed [EW-1:0] x1_reg;
   reg signed [EW-1:0] x2_reg;
   reg [SW-1:0] y1_reg;
   reg [SW-1:0] y2_reg;
   reg signed [AW-1:0] acc_reg;
   reg signed [AW-1:0] scaled_reg;
   reg [SW-1:0] result_reg;
   reg pending_reg;
   reg signed [CW-1:0] mac_coef;
   reg signed [EW:0] mac_data;
   wire signed [CW+EW:0] mac_prod;
   wire signed [AW-1:0] mac_term;
   wire signed [AW-1:0] acc_frac;
   wire signed [AW+CW-1:0] scale_prod;
   // sign-extended copies feed the two multipliers
   wire signed [CW+EW:0] mac_coef_x;
   wire signed [CW+EW:0] mac_data_x;
   wire signed [AW+CW-1:0] acc_frac_x;
   wire signed [AW+CW-1:0] gain_x;

   // the FIFO absorbs samples while a computation is in flight
   tptz_fifo #(
      .WIDTH(SW),
      .DEPTH(`TPTZ_FIFO_DEPTH),
      .AW(`TPTZ_FIFO_AW)
   ) u_fifo (
      .mclk(mclk),
      .rst(rst),
      .in_data(sample_data),
      .in_valid(sample_valid),
      .in_ready(fifo_in_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(take)
   );

   // one multiplier shared over five cycles; area traded for latency of a few cycles
   always @* begin
      mac_coef = {CW{1'b0}};
      mac_data = {(EW+1){1'b0}};
      case (step_reg)
         3'd0: begin
            mac_coef = coef_b0;
            mac_data = {x0_reg[EW-1], x0_reg};
         end
         3'd1: begin
            mac_coef = coef_b1;
            mac_data = {x1_reg[EW-1], x1_reg};
         end
         3'd2: begin
            mac_coef = coef_b2;
            mac_data = {x2_reg[EW-1], x2_reg};
         end
         3'd3: begin
            mac_coef = coef_a1;
            mac_data = {2'b00, y1_reg};
         end
         3'd4: begin
            mac_coef = coef_a2;
            mac_data = {2'b00, y2_reg};
         end
         default: begin
            mac_coef = {CW{1'b0}};
            mac_data = {(EW+1){1'b0}};
         end
      endcase
   end

   // factors are sign-extended to the product width first; the full product fits,
   // so nothing is padded or dropped implicitly inside the multiply
   assign mac_coef_x = {{(EW+1){mac_coef[CW-1]}}, mac_coef};
   assign mac_data_x = {{CW{mac_data[EW]}}, mac_data};
   assign mac_prod = mac_coef_x * mac_data_x;
   assign mac_term = {{(AW-CW-EW-1){mac_prod[CW+EW]}}, mac_prod};
   // drop the coefficient fraction once, before the gain multiply
   assign acc_frac = acc_reg >>> CF;
   assign acc_frac_x = {{CW{acc_frac[AW-1]}}, acc_frac};
   assign gain_x = {{AW{gain_k[CW-1]}}, gain_k};
   assign scale_prod = acc_frac_x * gain_x;

   // fifo output is taken only when idle, so one sample yields exactly one evaluation
   always @* begin
      take = (state_reg == S_IDLE) && fifo_valid;
   end

   // sequencer: mac, scale, saturate, then one wait cycle and back to idle
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg <= S_IDLE;
         step_reg <= 3'd0;
         x0_reg <= {EW{1'b0}};
         x1_reg <= {EW{1'b0}};
         x2_reg <= {EW{1'b0}};
         y1_reg <= {SW{1'b0}};
         y2_reg <= {SW{1'b0}};
         acc_reg <= {AW{1'b0}};
         scaled_reg <= {AW{1'b0}};
         result_reg <= `TPTZ_OUT_RESET;
         pending_reg <= 1'b0;
         demand_code <= `TPTZ_OUT_RESET;
         demand_update <= 1'b0;
         busy <= 1'b0;
         sample_ready <= 1'b0;
      end else begin
         sample_ready <= fifo_in_ready;
         demand_update <= 1'b0;
         // result presented only at a period boundary and held until the next one
         if (period_start && pending_reg) begin
            demand_code <= result_reg;
            demand_update <= 1'b1;
            pending_reg <= 1'b0;
         end
         case (state_reg)
            S_IDLE: begin
               busy <= 1'b0;
               if (take) begin
                  // error is set point minus sample, both in the converter's scaling
                  x0_reg <= $signed({1'b0, set_point}) - $signed({1'b0, fifo_data});
                  x1_reg <= x0_reg;
                  x2_reg <= x1_reg;
                  acc_reg <= {AW{1'b0}};
                  step_reg <= 3'd0;
                  busy <= 1'b1;
                  state_reg <= S_MAC;
               end
            end
            S_MAC: begin
               acc_reg <= acc_reg + mac_term;
               if (step_reg == 3'd4) begin
                  state_reg <= S_SCALE;
               end else begin
                  step_reg <= step_reg + 3'd1;
               end
            end
            S_SCALE: begin
               // limitation: a scaled value beyond 48 bits wraps, so gains must stay sane
               scaled_reg <= scale_prod[AW+CF-1:CF];
               state_reg <= S_SAT;
            end
            S_SAT: begin
               // clamp stops windup: history holds what the converter really got
               if (scaled_reg[AW-1]) begin
                  result_reg <= {SW{1'b0}};
                  y1_reg <= {SW{1'b0}};
               end else if (scaled_reg > $signed({{(AW-SW){1'b0}}, `TPTZ_CODE_MAX})) begin
                  result_reg <= `TPTZ_CODE_MAX;
                  y1_reg <= `TPTZ_CODE_MAX;
               end else begin
                  result_reg <= scaled_reg[SW-1:0];
                  y1_reg <= scaled_reg[SW-1:0];
               end
               y2_reg <= y1_reg;
               pending_reg <= 1'b1;
               state_reg <= S_WAIT;
            end
            S_WAIT: begin
               busy <= 1'b0;
               state_reg <= S_IDLE;
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// file: tptz_monitor.sv
// tptz_monitor.sv: port timing checks for the compensator
// assumes: bound to tptz_compensator, one clock, async active-high reset
`timescale 1ns/1ps
module tptz_monitor (
   input wire mclk,
   input wire rst,
   input wire sample_valid,
   input wire sample_ready,
   input wire period_start,
   input wire [11:0] demand_code,
   input wire demand_update,
   input wire busy
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   reg pend_reg;
   reg busy_d_reg;
   reg [7:0] credit_reg;
   wire busy_rise;
   assign busy_rise = busy & ~busy_d_reg;
   // pend marks a started computation not yet presented; credit counts offered
   // cycles not yet used, every rise of busy uses one, so evaluations can never outrun it
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         pend_reg <= 1'b0;
         busy_d_reg <= 1'b0;
         credit_reg <= 8'h00;
      end else begin
         busy_d_reg <= busy;
         if (sample_valid && !busy_rise && credit_reg != 8'hff) begin
            credit_reg <= credit_reg + 8'h01;
         end else if (!sample_valid && busy_rise && credit_reg != 8'h00) begin
            credit_reg <= credit_reg - 8'h01;
         end
         if (busy_rise) begin
            pend_reg <= 1'b1;
         end else if (demand_update) begin
            pend_reg <= 1'b0;
         end
      end
   end
   property p_upd_start; demand_update |-> $past(period_start); endproperty
   a_upd_start: assert property (p_upd_start) else $error("update off period");
   property p_hold; !demand_update |-> $stable(demand_code); endproperty
   a_hold: assert property (p_hold) else $error("demand moved");
   property p_pulse; demand_update |=> !demand_update; endproperty
   a_pulse: assert property (p_pulse) else $error("update too long");
   property p_busy_len; $rose(busy) |-> busy[*8]; endproperty
   a_busy_len: assert property (p_busy_len) else $error("compute too short");
   property p_busy_cause; $rose(busy) |-> credit_reg != 8'h00; endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("compute w/o sample");
   property p_pend_upd; period_start && pend_reg && !busy |=> demand_update; endproperty
   a_pend_upd: assert property (p_pend_upd) else $error("result not shown");
   property p_rst_out; $fell(rst) |-> demand_code == 12'h000 && !demand_update && !busy;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("reset outputs");
   property p_rst_rdy; $fell(rst) |=> sample_ready; endproperty
   a_rst_rdy: assert property (p_rst_rdy) else $error("not ready");
   c_upd: cover property (demand_update);
   c_full: cover property (sample_valid && !sample_ready);
   c_take: cover property ($rose(busy));
endmodule
bind tptz_compensator tptz_monitor u_mon (.mclk(mclk), .rst(rst),
   .sample_valid(sample_valid), .sample_ready(sample_ready),
   .period_start(period_start), .demand_code(demand_code),
   .demand_update(demand_update), .busy(busy));

// file: tptz_adc_model.sv
// tptz_adc_model.sv: converter sampling once a period, plus period timer
// assumes: code and en from the bench; burst forces back-to-back pushes
`timescale 1ns/1ps
module tptz_adc_model #(
   parameter [7:0] LAST = 8'd39,
   parameter [7:0] LATE = 8'd25
) (
   input wire mclk,
   input wire rst,
   input wire en,
   input wire burst,
   input wire [11:0] code,
   input wire sample_ready,
   output reg [11:0] sample_data,
   output reg sample_valid,
   output reg period_start
);
   reg [7:0] tick_reg;
   // late trigger shortens the calculation delay; data inverts once released
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         tick_reg <= 8'h00;
         sample_valid <= 1'b0;
         sample_data <= 12'h000;
         period_start <= 1'b0;
      end else begin
         tick_reg <= (tick_reg == LAST) ? 8'h00 : tick_reg + 8'h01;
         period_start <= (tick_reg == LAST);
         if (burst || (en && tick_reg == LATE)) begin
            sample_valid <= 1'b1;
            sample_data <= code;
         end else if (sample_valid && sample_ready) begin
            sample_valid <= 1'b0;
            sample_data <= ~sample_data;
         end
      end
   end
endmodule

// file: tptz_compensator_tb.sv
// tptz_compensator_tb.sv: self-checking bench for the compensator
// assumes: monitor and converter model compiled first
`timescale 1ns/1ps
module tptz_compensator_tb;
   reg mclk = 1'b0;
   reg rst = 1'b1;
   reg en = 1'b0;
   reg burst = 1'b0;
   reg [11:0] code = 12'h000;
   reg [11:0] sp = 12'h800;
   reg signed [17:0] a1 = 18'sh00800, a2 = 18'sh00400, b0 = 18'sh01000;
   reg signed [17:0] b1 = 18'sh00800, b2 = 18'sh3fc00, k = 18'sh02000;
   wire [11:0] sd, dc;
   wire sv, sr, ps, du, busy;
   integer miscompares = 0, n_checks = 0, cyc = 0;
   longint x1 = 0, x2 = 0, y1 = 0, y2 = 0;
   always #10 mclk = ~mclk;
   // cut a hang short
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         wrap_up;
      end
   end
   tptz_adc_model u_adc (.mclk(mclk), .rst(rst), .en(en), .burst(burst), .code(code),
      .sample_ready(sr), .sample_data(sd), .sample_valid(sv), .period_start(ps));
   tptz_compensator u_dut (.mclk(mclk), .rst(rst), .sample_data(sd), .sample_valid(sv),
      .sample_ready(sr), .period_start(ps), .set_point(sp), .coef_a1(a1), .coef_a2(a2),
      .coef_b0(b0), .coef_b1(b1), .coef_b2(b2), .gain_k(k), .demand_code(dc),
      .demand_update(du), .busy(busy));
   task chk(input logic [11:0] seen, input logic [11:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value t=%0t got %h exp %h", $time, seen, exp);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // reference keeps its own history, storing the clamped output
   task ref_y(input logic [11:0] s, output logic [11:0] y);
      longint x0, acc;
      x0 = longint'(sp) - longint'(s);
      acc = b0 * x0 + b1 * x1 + b2 * x2 + a1 * y1 + a2 * y2;
      acc = ((acc >>> 12) * k) >>> 12;
      acc = acc < 0 ? 0 : (acc > 4095 ? 4095 : acc);
      x2 = x1;
      x1 = x0;
      y2 = y1;
      y1 = acc;
      y = acc[11:0];
   endtask
   task t_reset;
      chk(dc, 12'h000);
      chk({11'h000, busy}, 12'h000);
   endtask
   // normal, clamp high, clamp low and zero-error samples, two coefficient sets
   task t_track(input bit retune);
      logic [11:0] tbl [0:4];
      logic [11:0] y;
      integer i, j;
      tbl = '{12'h7d0, 12'h400, 12'h000, 12'hfff, 12'h800};
      for (i = 0; i < 5; i++) begin
         @(posedge mclk);
         code <= tbl[i];
         en <= 1'b1;
         if (retune && i == 0) begin
            sp <= 12'h600;
            a1 <= 18'sh00c00;
            a2 <= 18'sh00100;
            b0 <= 18'sh00800;
            b1 <= 18'sh3f800;
            b2 <= 18'sh00200;
            k <= 18'sh01800;
         end
         // a negative gain on the last retuned sample pushes the result below zero
         if (retune && i == 4) begin
            k <= 18'sh3e800;
         end
         @(posedge mclk) #1;
         ref_y(tbl[i], y);
         for (j = 0; j < 200 && du !== 1'b1; j++) @(posedge mclk) #1;
         chk({11'h000, du}, 12'h001);
         chk(dc, y);
      end
   endtask
   // overfill the sample buffer, then let it drain
   task t_fill;
      logic full;
      integer j, idle;
      full = 1'b0;
      idle = 0;
      @(posedge mclk);
      en <= 1'b0;
      burst <= 1'b1;
      for (j = 0; j < 40; j++) begin
         @(posedge mclk) #1;
         full = full | (sr === 1'b0);
      end
      @(posedge mclk);
      burst <= 1'b0;
      for (j = 0; j < 600 && idle < 12; j++) begin
         @(posedge mclk) #1;
         idle = busy ? 0 : idle + 1;
      end
      chk({11'h000, full}, 12'h001);
      chk({10'h000, busy, sr}, 12'h001);
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk) #1;
      t_reset;
      t_track(1'b0);
      t_track(1'b1);
      t_fill;
      wrap_up;
   end
endmodule
